// ===== src/mpd_pkg.sv
package mpd_pkg;
    // ==========================================
    // Widths, reset values and saturation maximum
    localparam int MPD_CNT_W = 16;
    localparam logic [15:0] MPD_CNT_RESET = 16'h0000;
    localparam logic [15:0] MPD_PER_RESET = 16'h0000;
    localparam logic [15:0] MPD_SAT_MAX = 16'hFFFF;
    // ==========================================
    // Operating modes
    localparam logic MPD_MODE_SINGLE = 1'b0;
    localparam logic MPD_MODE_MULTI = 1'b1;
    localparam logic MPD_SEL_FIXED = 1'b0;
    localparam logic MPD_SEL_ADAPTIVE = 1'b1;
endpackage

// ===== src/mpd_missing_pulse_detector.sv
`timescale 1ns/10ps
// How it works
// - While the period counter runs, the counter minus the latched period is formed every cycle in both modes.
// - That difference is compared with the chosen threshold and a miss event fires exactly on equality.
// - With adaptive select at 1 the threshold is the latched period halved.
// - Adaptive mode thus flags a miss when no pulse comes within 1.5 times the last interval.
// - In adaptive mode the threshold follows each newly latched period.
// - With adaptive select at 0 the software miss threshold value is used, unaffected by period changes.
// - In single-pulse mode a miss event pulses the miss output and sets the miss event flag.
// - In multi-pulse mode a miss event also does that and serves as a period signal timing point.
module mpd_missing_pulse_detector
#(
    parameter int CNT_W = mpd_pkg::MPD_CNT_W
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic pulse_in,
    input wire logic adaptive_miss_select,
    input wire logic multi_pulse_mode,
    input wire logic [CNT_W-1:0] miss_threshold_value,
    input wire logic miss_flag_clear,
    output logic miss_out,
    output logic miss_event_flag,
    output logic period_tick,
    output logic [CNT_W-1:0] period_latch_value,
    output logic [CNT_W-1:0] period_count
);
    import mpd_pkg::*;

    // ==========================================
    // Local constants
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_TOP = {CNT_W{1'b1}};
    localparam logic [CNT_W-1:0] CNT_CLEAR = CNT_W'(MPD_CNT_RESET);
    localparam logic [CNT_W-1:0] PER_CLEAR = CNT_W'(MPD_PER_RESET);

    // ==========================================
    // State
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] per;
        logic pulse_d;
        logic miss;
        logic flag;
        logic tick;
    } mpd_state_t;

    localparam mpd_state_t ST_RESET = '{
        cnt: CNT_CLEAR,
        per: PER_CLEAR,
        pulse_d: 1'b0,
        miss: 1'b0,
        flag: 1'b0,
        tick: 1'b0
    };

    mpd_state_t st;
    mpd_state_t next_st;
    logic rise;
    logic past_per;
    logic [CNT_W-1:0] diff;
    logic [CNT_W-1:0] thresh;
    logic hit;
    logic tick_on_miss;
    logic flag_set;

    // ==========================================
    // Helpers
    // Rising edge against the last sample
    function automatic logic edge_seen(input logic now_lvl, input logic last_lvl);
        return now_lvl & ~last_lvl;
    endfunction

    // Running difference, wraps below the period
    function automatic logic [CNT_W-1:0] count_minus_period(
        input logic [CNT_W-1:0] count,
        input logic [CNT_W-1:0] period
    );
        return count - period;
    endfunction

    // Half of the latched period
    function automatic logic [CNT_W-1:0] half_period(input logic [CNT_W-1:0] period);
        return period >> 1;
    endfunction

    // Adaptive or fixed threshold
    function automatic logic [CNT_W-1:0] select_threshold(
        input logic adaptive,
        input logic [CNT_W-1:0] period,
        input logic [CNT_W-1:0] fixed_value
    );
        logic [CNT_W-1:0] pick;
        if (adaptive == MPD_SEL_ADAPTIVE)
        begin
            pick = half_period(period);
        end
        else
        begin
            pick = fixed_value;
        end
        return pick;
    endfunction

    // Saturating count step
    function automatic logic [CNT_W-1:0] step_count(input logic [CNT_W-1:0] count);
        logic [CNT_W-1:0] stepped;
        if (count == CNT_TOP)
        begin
            stepped = count;
        end
        else
        begin
            stepped = count + CNT_ONE;
        end
        return stepped;
    endfunction

    // Equality against the threshold, only once at or past the period
    function automatic logic miss_compare(
        input logic run,
        input logic new_pulse,
        input logic past_period,
        input logic [CNT_W-1:0] difference,
        input logic [CNT_W-1:0] limit
    );
        return run && !new_pulse && past_period && (difference == limit);
    endfunction

    // Set wins over clear
    function automatic logic next_flag(
        input logic old_flag,
        input logic set_req,
        input logic clear_req
    );
        logic result;
        result = old_flag;
        if (clear_req)
        begin
            result = 1'b0;
        end
        if (set_req)
        begin
            result = 1'b1;
        end
        return result;
    endfunction

    // Period signal on a pulse or a counted miss
    function automatic logic period_signal(
        input logic run,
        input logic new_pulse,
        input logic miss_tick
    );
        return (run && new_pulse) || miss_tick;
    endfunction

    // ==========================================
    // Pulse edge and threshold
    always_comb
    begin
        rise = edge_seen(pulse_in, st.pulse_d);
        past_per = (st.cnt >= st.per);
        diff = count_minus_period(st.cnt, st.per);
        thresh = select_threshold(adaptive_miss_select, st.per, miss_threshold_value);
    end

    // ==========================================
    // Miss comparison
    always_comb
    begin
        // Counter at or beyond the latched period; with adaptive select the miss comes at 1.5 periods, else at period plus miss_threshold_value
        hit = miss_compare(enable, rise, past_per, diff, thresh);
        tick_on_miss = hit && (multi_pulse_mode == MPD_MODE_MULTI);
        flag_set = hit;
    end

    // ==========================================
    // Next state
    always_comb
    begin
        next_st = st;
        next_st.pulse_d = pulse_in;
        // Counter and period latch
        if (!enable)
        begin
            next_st.cnt = CNT_CLEAR;
        end
        else if (rise)
        begin
            next_st.per = st.cnt;
            next_st.cnt = CNT_ONE;
        end
        else
        begin
            next_st.cnt = step_count(st.cnt);
        end
        // Miss output is a one-cycle pulse while the threshold is steady, except while the counter is held at its top value
        next_st.miss = hit;
        // Period signal on each pulse while enabled and, in multi-pulse mode, on a miss
        next_st.tick = period_signal(enable, rise, tick_on_miss);
        next_st.flag = next_flag(st.flag, flag_set, miss_flag_clear);
    end

    // ==========================================
    // State register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= ST_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ==========================================
    // Outputs
    assign miss_out = st.miss;
    assign miss_event_flag = st.flag;
    assign period_tick = st.tick;
    assign period_latch_value = st.per;
    assign period_count = st.cnt;
endmodule

// ===== testbench/mpd_pulse_src.sv
`timescale 1ns/10ps
module mpd_pulse_src (input wire logic clock, input wire logic [7:0] gap, output logic pulse_in);
    int n = 0;
    initial pulse_in = 1'b0;
    // One-cycle pulse, low between pulses
    always @(posedge clock)
    begin
        n <= (n >= gap) ? 0 : n + 1;
        pulse_in <= (n == gap);
    end
endmodule

// ===== testbench/mpd_assertions.sv
`timescale 1ns/10ps
module mpd_chk (input wire logic clock, input wire logic rst_n, input wire logic enable,
    input wire logic pulse_in, input wire logic multi_pulse_mode, input wire logic miss_out,
    input wire logic miss_event_flag, input wire logic period_tick, input wire logic [15:0] period_count,
    input wire logic miss_flag_clear, input wire logic adaptive_miss_select,
    input wire logic [15:0] miss_threshold_value);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_rise; enable && pulse_in && !$past(pulse_in); endsequence
    sequence s_hold_flag; miss_event_flag && !miss_flag_clear; endsequence
    sequence s_miss_steady; miss_out && period_count != 16'hFFFF && $stable(adaptive_miss_select)
        && $stable(miss_threshold_value); endsequence
    property p_flag_hold; s_hold_flag |=> miss_event_flag; endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag hold");
    property p_off; !enable |=> period_count == 16'h0000 && !miss_out; endproperty
    a_off: assert property (p_off) else $error("counter off");
    property p_step; enable && !pulse_in && period_count != 16'hFFFF |=>
        period_count == $past(period_count) + 16'h0001; endproperty
    a_step: assert property (p_step) else $error("counter step");
    property p_once; s_miss_steady |=> !miss_out; endproperty
    a_once: assert property (p_once) else $error("single miss");
    property p_restart; s_rise |=> period_count == 16'h0001 && period_tick; endproperty
    a_restart: assert property (p_restart) else $error("restart");
    property p_flag; miss_out |-> miss_event_flag; endproperty
    a_flag: assert property (p_flag) else $error("flag");
    property p_tick; miss_out && $past(multi_pulse_mode) |-> period_tick; endproperty
    a_tick: assert property (p_tick) else $error("tick");
endmodule
bind mpd_missing_pulse_detector mpd_chk mpd_chk_i (.clock, .rst_n, .enable, .pulse_in, .multi_pulse_mode,
    .miss_out, .miss_event_flag, .period_tick, .period_count, .miss_flag_clear, .adaptive_miss_select,
    .miss_threshold_value);

// ===== testbench/missing_pulse_detector_tb_top.sv
`timescale 1ns/10ps
module missing_pulse_detector_tb_top;
    logic clock = 0, rst_n = 0, pulse_in, am = 0, mm = 0, clr = 0, en = 1, mo, mf, tk;
    logic [15:0] thr = 16'h0010, per, cnt;
    logic [7:0] gap = 8'h08;
    int fails = 0, compares = 0, ec = 0, ep = 0, ef = 0, em = 0, et = 0, pp = 0, r, h;
    always #20 clock = ~clock;
    mpd_pulse_src mpd_pulse_src_i (.clock, .gap, .pulse_in);
    mpd_missing_pulse_detector mpd_missing_pulse_detector_i (.clock, .rst_n, .enable(en), .pulse_in,
        .adaptive_miss_select(am), .multi_pulse_mode(mm), .miss_threshold_value(thr), .miss_flag_clear(clr),
        .miss_out(mo), .miss_event_flag(mf), .period_tick(tk), .period_latch_value(per), .period_count(cnt));
    task chk(string s, int e, logic [15:0] g);
        compares++;
        if (g !== 16'(e))
        begin
            fails++;
            $display("[ERR] %s exp %0h got %0h", s, e, g);
        end
    endtask
    task give_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Reference model
    always @(posedge clock)
    if (rst_n)
    begin
        r = pulse_in && !pp;
        h = en && !r && ec >= ep && ec - ep == (am ? ep / 2 : int'(thr));
        pp = pulse_in;
        em = h;
        ef = h || (ef && !clr);
        et = (en && r) || (h && mm);
        if (!en) ec = 0;
        else if (r) {ep, ec} = {ec, 32'd1};
        else if (ec < 65535) ec++;
    end
    always @(negedge clock)
    if (rst_n)
    begin
        chk("miss", em, {15'h0000, mo});
        chk("flag", ef, {15'h0000, mf});
        chk("tick", et, {15'h0000, tk});
        chk("per", ep, per);
        chk("cnt", ec, cnt);
    end
    initial
    begin
        void'($urandom(50450));
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        for (int t = 0; t < 8; t++)
        begin
            am <= t[0];
            mm <= t[1];
            thr <= 16'($urandom % 24);
            repeat (12)
            begin
                @(posedge clock);
                gap <= 8'(2 + $urandom % 30);
                clr <= 1'($urandom % 2);
                en <= 1'($urandom % 8 != 0);
                repeat (40) @(posedge clock);
            end
            $display("test %0d done", t);
        end
        give_verdict;
    end
endmodule
